// File: src/hm_homing.sv
// homing sequencer with automatic return off or back past the proximity dog,
// discrete input filtering and the latched virtual pulses per revolution setting
// assumes raw pins from outside the clock domain and settings from same-clock logic
`timescale 1ns/1ps

module hm_homing #(
  parameter int unsigned FILTER_UNIT_CYCLES = hm_pkg::FILTER_UNIT_CYC
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire hm_pkg::hm_pins_s   pinsRaw,
  input  wire logic               programMethod,
  input  wire logic               homeForward,
  input  wire logic [7:0]         inputFilterTimeSetting,
  input  wire logic [15:0]        homeSpeedSetting,
  input  wire logic [15:0]        creepSpeedSetting,
  input  wire logic [15:0]        homeAccelSetting,
  input  wire logic               softLimitSetting,
  input  wire logic [15:0]        virtualPulsesPerRevSetting,
  input  wire logic [31:0]        encoderResolution,
  output hm_pkg::hm_motion_s      motion_r,
  output logic                    softLimitEn_r,
  output logic                    homeBusy_r,
  output logic                    homeDone_r,
  output logic                    warnActive_r,
  output logic [11:0]             warnCode_r,
  output logic [31:0]             pulsesPerRev_r
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic pprValid(input logic [15:0] v);
    pprValid = (v == 16'h0000) || ((v >= hm_pkg::PPR_SET_MIN) && (v <= hm_pkg::PPR_SET_MAX));
  endfunction

  function automatic logic endAhead(input hm_pkg::hm_pins_s p, input logic fwd);
    endAhead = fwd ? p.forwardStrokeEnd : p.reverseStrokeEnd;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: two flops, only the second one feeds the filter

  logic [hm_pkg::PIN_COUNT-1:0] syncA_r;
  logic [hm_pkg::PIN_COUNT-1:0] syncB_r;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      syncA_r <= '0;
      syncB_r <= '0;
    end
    else
    begin
      syncA_r <= pinsRaw;
      syncB_r <= syncA_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input filter: a level is accepted only after it held for the filter time

  logic [31:0]                  filterLimit;
  logic [hm_pkg::PIN_COUNT-1:0] filt_r;
  hm_pkg::hm_pins_s             pins;

  assign filterLimit = 32'(inputFilterTimeSetting) * 32'(FILTER_UNIT_CYCLES);
  assign pins        = hm_pkg::hm_pins_s'(filt_r);

  for (genvar i = 0; i < hm_pkg::PIN_COUNT; i++)
  begin : g_filter
    logic [31:0] cnt_r;

    // glitches shorter than the filter time restart the count and never pass
    always_ff @(posedge clk_sys)
    begin
      if (!resetn)
      begin
        cnt_r     <= '0;
        filt_r[i] <= 1'b0;
      end
      else if (syncB_r[i] == filt_r[i])
      begin
        cnt_r <= '0;
      end
      else if (cnt_r >= filterLimit)
      begin
        cnt_r     <= '0;
        filt_r[i] <= syncB_r[i];
      end
      else
      begin
        cnt_r <= cnt_r + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // homing request decode

  logic startPrev_r;
  logic homeSelected;
  logic startHome;

  // point method needs all selects off, program method needs the home command
  assign homeSelected = pins.autoManualSelect &&
                        (programMethod ? pins.homeReturnCommand
                                       : (pins.pointSelect == 3'h0));
  assign startHome    = pins.startRequest && !startPrev_r && homeSelected;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      startPrev_r <= 1'b0;
    else
      startPrev_r <= pins.startRequest;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  hm_pkg::hm_state_e state_r;
  hm_pkg::hm_state_e state_nxt;
  logic              dirFwd;
  logic              sawDog_r;
  logic              hitEnd;

  // travel direction is a pure function of the state and homeForward
  always_comb
  begin
    case (state_r)
      hm_pkg::ST_OFFDOG: dirFwd = !homeForward;
      hm_pkg::ST_RETURN: dirFwd = !homeForward;
      default:           dirFwd = homeForward;
    endcase
  end

  assign hitEnd = endAhead(pins, dirFwd);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      hm_pkg::ST_IDLE:
        if (startHome)
          state_nxt = pins.proximityDog ? hm_pkg::ST_OFFDOG
                                        : hm_pkg::ST_FAST;
      hm_pkg::ST_OFFDOG:
        if (hitEnd)
          state_nxt = hm_pkg::ST_FAIL;
        else if (!pins.proximityDog)
          state_nxt = hm_pkg::ST_PAUSE;
      hm_pkg::ST_FAST:
        if (pins.proximityDog)
          state_nxt = hm_pkg::ST_CREEP;
        else if (hitEnd)
          state_nxt = hm_pkg::ST_RETURN;
      hm_pkg::ST_RETURN:
        if (sawDog_r && !pins.proximityDog)
          state_nxt = hm_pkg::ST_PAUSE;
        else if (hitEnd && !sawDog_r && !pins.proximityDog)
          state_nxt = hm_pkg::ST_FAIL;
      hm_pkg::ST_PAUSE:
        state_nxt = hm_pkg::ST_FAST;
      hm_pkg::ST_CREEP:
        if (!pins.proximityDog)
          state_nxt = hm_pkg::ST_IDLE;
      hm_pkg::ST_FAIL:
        if (startHome)
          state_nxt = pins.proximityDog ? hm_pkg::ST_OFFDOG : hm_pkg::ST_FAST;
      default:
        state_nxt = hm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      state_r <= hm_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // remembers that the dog was met while travelling back
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      sawDog_r <= 1'b0;
    else if (state_r != hm_pkg::ST_RETURN)
      sawDog_r <= 1'b0;
    else if (pins.proximityDog)
      sawDog_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // motion command, registered from the next state so it tracks the state

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      motion_r <= hm_pkg::MOTION_RESET;
    else
    begin
      motion_r.accelTime <= homeAccelSetting;
      case (state_nxt)
        hm_pkg::ST_OFFDOG, hm_pkg::ST_RETURN:
        begin
          motion_r.enable  <= 1'b1;
          motion_r.forward <= !homeForward;
          motion_r.speed   <= homeSpeedSetting;
        end
        hm_pkg::ST_FAST:
        begin
          motion_r.enable  <= 1'b1;
          motion_r.forward <= homeForward;
          motion_r.speed   <= homeSpeedSetting;
        end
        hm_pkg::ST_CREEP:
        begin
          motion_r.enable  <= 1'b1;
          motion_r.forward <= homeForward;
          motion_r.speed   <= creepSpeedSetting;
        end
        default:
        begin
          motion_r.enable  <= 1'b0;
          motion_r.forward <= motion_r.forward;
          motion_r.speed   <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status: busy, done, warning and software limit gate

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      homeBusy_r    <= 1'b0;
      homeDone_r    <= 1'b0;
      warnActive_r  <= 1'b0;
      warnCode_r    <= hm_pkg::WARN_NONE;
      softLimitEn_r <= 1'b0;
    end
    else
    begin
      homeBusy_r    <= (state_nxt != hm_pkg::ST_IDLE) && (state_nxt != hm_pkg::ST_FAIL);
      // limits would stop the deliberate run onto the stroke end
      softLimitEn_r <= softLimitSetting && (state_nxt == hm_pkg::ST_IDLE);
      if (state_r == hm_pkg::ST_CREEP && state_nxt == hm_pkg::ST_IDLE)
        homeDone_r <= 1'b1;
      else if (startHome)
        homeDone_r <= 1'b0;
      if (state_nxt == hm_pkg::ST_FAIL)
      begin
        warnActive_r <= 1'b1;
        warnCode_r   <= {hm_pkg::WARN_MAJOR, hm_pkg::WARN_MINOR};
      end
      else
      begin
        warnActive_r <= 1'b0;
        warnCode_r   <= hm_pkg::WARN_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulses per revolution, taken once after reset release and then frozen

  logic pprLoaded_r;

  // a write while running never reaches the scaling, only a reset does
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pprLoaded_r    <= 1'b0;
      pulsesPerRev_r <= hm_pkg::PPR_RESET;
    end
    else if (!pprLoaded_r)
    begin
      pprLoaded_r <= 1'b1;
      if (!pprValid(virtualPulsesPerRevSetting))
        pulsesPerRev_r <= pulsesPerRev_r;
      else if (virtualPulsesPerRevSetting == 16'h0000)
        pulsesPerRev_r <= encoderResolution;
      else
        pulsesPerRev_r <= 32'(virtualPulsesPerRevSetting) * hm_pkg::PPR_SCALE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_endInReturn;
    state_r == hm_pkg::ST_FAST && !pins.proximityDog && hitEnd;
  endsequence

  sequence s_backwards;
    state_r == hm_pkg::ST_RETURN && motion_r.forward == !homeForward;
  endsequence

  sequence s_pastDog;
    state_r == hm_pkg::ST_RETURN && sawDog_r && !pins.proximityDog;
  endsequence

  sequence s_stopThenGo;
    state_r == hm_pkg::ST_PAUSE && !motion_r.enable
    ##1 state_r == hm_pkg::ST_FAST && motion_r.enable;
  endsequence

  a_soft_limit_off: assert property (homeBusy_r |-> !softLimitEn_r)
    else $error("software limit active during homing");
  a_reverse_on_end: assert property (s_endInReturn |=> s_backwards)
    else $error("stroke end did not reverse travel");
  a_stop_past_dog: assert property (s_pastDog |=> s_stopThenGo)
    else $error("no stop and restart after dog front end");
  a_leave_dog_first: assert property (
    (state_r == hm_pkg::ST_IDLE && startHome && pins.proximityDog)
    |=> state_r == hm_pkg::ST_OFFDOG && motion_r.forward == !homeForward)
    else $error("start on dog did not move off it first");
  a_start_home_dir: assert property (
    (state_r == hm_pkg::ST_IDLE && startHome && !pins.proximityDog)
    |=> motion_r.enable && motion_r.forward == homeForward)
    else $error("start beyond dog not in home direction");
  a_warn_on_fail: assert property (
    (state_r == hm_pkg::ST_RETURN && hitEnd && !sawDog_r && !pins.proximityDog)
    |=> warnActive_r && !motion_r.enable
        && warnCode_r == {hm_pkg::WARN_MAJOR, hm_pkg::WARN_MINOR})
    else $error("missing dog did not stop with warning");
  a_creep_speed: assert property (
    state_r == hm_pkg::ST_CREEP |-> motion_r.speed == $past(creepSpeedSetting))
    else $error("creep speed not applied after dog");
  a_ppr_zero: assert property ((!pprLoaded_r && virtualPulsesPerRevSetting == 16'h0000)
    |=> pulsesPerRev_r == $past(encoderResolution))
    else $error("setting 0 did not give encoder resolution");
  a_ppr_scaled: assert property (
    (!pprLoaded_r && virtualPulsesPerRevSetting >= hm_pkg::PPR_SET_MIN
     && virtualPulsesPerRevSetting <= hm_pkg::PPR_SET_MAX)
    |=> pulsesPerRev_r == 32'($past(virtualPulsesPerRevSetting)) * 32'h0000_0064)
    else $error("pulses per revolution not setting times 100");
  a_ppr_frozen: assert property (pprLoaded_r |=> $stable(pulsesPerRev_r))
    else $error("pulses per revolution changed without reset");
  a_ppr_invalid: assert property ((!pprLoaded_r && !pprValid(virtualPulsesPerRevSetting))
    |=> pulsesPerRev_r == hm_pkg::PPR_RESET)
    else $error("invalid pulse setting was taken");
  // only the bits that moved are compared: other pins may be mid-filter at that edge
  a_filter_hold: assert property ($changed(filt_r) |->
    ((filt_r ^ $past(filt_r)) & (filt_r ^ $past(syncB_r))) == '0)
    else $error("filter passed a level the pin does not show");

endmodule // hm_homing

// File: src/hm_pkg.sv
// homing sequencer package: pin bundle, state list, timing and setting constants
// assumes a 10 MHz system clock and active-high filtered pin levels
package hm_pkg;

  // system clock period and filter time base
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned FILTER_UNIT_NS    = 1000000;    // one setting step is 1 ms
  localparam int unsigned FILTER_UNIT_CYC   = (FILTER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // virtual pulses per revolution setting
  localparam logic [15:0] PPR_SET_RESET     = 16'h0064;   // 100 -> 10000 pulses
  localparam logic [15:0] PPR_SET_MIN       = 16'h0064;   // 100
  localparam logic [15:0] PPR_SET_MAX       = 16'h01F4;   // 500
  localparam logic [31:0] PPR_SCALE         = 32'h0000_0064; // setting times 100
  localparam logic [31:0] PPR_RESET         = 32'h0000_2710; // 10000

  // homing-incomplete warning, 90.2
  localparam logic [7:0]  WARN_MAJOR        = 8'h5A;
  localparam logic [3:0]  WARN_MINOR        = 4'h2;
  localparam logic [11:0] WARN_NONE         = 12'h000;

  // pin bundle after synchronising and filtering
  typedef struct packed {
    logic       forwardStrokeEnd;
    logic       reverseStrokeEnd;
    logic       proximityDog;
    logic [2:0] pointSelect;
    logic       autoManualSelect;
    logic       homeReturnCommand;
    logic       startRequest;
  } hm_pins_s;

  localparam int unsigned PIN_COUNT = $bits(hm_pins_s);
  localparam hm_pins_s    PINS_RESET = '0;

  // motion command bundle
  typedef struct packed {
    logic        enable;
    logic        forward;
    logic [15:0] speed;
    logic [15:0] accelTime;
  } hm_motion_s;

  localparam hm_motion_s MOTION_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OFFDOG,
    ST_FAST,
    ST_RETURN,
    ST_PAUSE,
    ST_CREEP,
    ST_FAIL
  } hm_state_e;

endpackage

// File: verif/hm_axis_model.sv
// axis and sensor model: one position step per enabled clock, sensors decoded from position
// assumes stroke ends at 0 and 100 and a dog spanning 60..80 that can be removed
`timescale 1ns/1ps

module hm_axis_model (
  input  wire logic               clk_sys,
  input  wire hm_pkg::hm_motion_s motion,
  input  wire logic               setStb,
  input  wire logic [7:0]         setPos,
  input  wire logic               dogEn,
  output logic                    fwdEnd,
  output logic                    revEnd,
  output logic                    dog
);
  logic [7:0] pos;

  ////////////////////////////////////////////////////////////////////////////
  // position clamps at the stroke ends, the axis cannot overrun them
  always @(posedge clk_sys)
  begin
    if (setStb)
      pos <= setPos;
    else if (motion.enable && motion.forward && pos < 8'h64)
      pos <= pos + 8'h01;
    else if (motion.enable && !motion.forward && pos > 8'h00)
      pos <= pos - 8'h01;
  end

  // sensors follow position; dogEn low models a missing dog
  assign fwdEnd = (pos >= 8'h64);
  assign revEnd = (pos == 8'h00);
  assign dog    = dogEn && (pos >= 8'h3C) && (pos <= 8'h50);
endmodule // hm_axis_model

// File: verif/hm_homing_tb.sv
// self-checking bench for the homing sequencer against the axis model
// assumes the design runs with a 2-cycle filter unit to keep runs short
`timescale 1ns/1ps

module hm_homing_tb;
  localparam logic [15:0] HOME_SPD  = 16'h0100;
  localparam logic [15:0] CREEP_SPD = 16'h0010;
  localparam logic [15:0] ACC       = 16'h0020;
  localparam logic [31:0] ENC_RES   = 32'h0002_0000;

  logic               clk_sys  = 1'b0;
  logic               resetn   = 1'b0;
  logic               progM    = 1'b0;
  logic               homeFwd  = 1'b1;
  logic [7:0]         filt     = 8'h00;
  logic [15:0]        ppr      = 16'h0064;
  logic [2:0]         pointSel = 3'h0;
  logic               autoMan  = 1'b1;
  logic               homeCmd  = 1'b0;
  logic               startReq = 1'b0;
  logic               setStb   = 1'b1;
  logic [7:0]         setPos   = 8'h5A;
  logic               dogEn    = 1'b1;
  logic               softSet  = 1'b1;
  logic               fwdEnd, revEnd, dog;
  hm_pkg::hm_pins_s   pinsRaw;
  hm_pkg::hm_motion_s motion;
  logic               softLim, busy, done, warn;
  logic [11:0]        code;
  logic [31:0]        pulses;
  int                 mismatches = 0;
  int                 tests_run  = 0;
  logic               firstFwd, sawMove, sawCreep, badProf, limitOn;
  int                 dirChg, lat, lat0;

  ////////////////////////////////////////////////////////////////////////////
  // clock and pin bundle; sensors come from the model, the rest from the bench
  always #50 clk_sys = ~clk_sys;
  assign pinsRaw = {fwdEnd, revEnd, dog, pointSel, autoMan, homeCmd, startReq};

  hm_homing #(.FILTER_UNIT_CYCLES(2)) hm_homing_i (
    .clk_sys(clk_sys), .resetn(resetn), .pinsRaw(pinsRaw), .programMethod(progM),
    .homeForward(homeFwd), .inputFilterTimeSetting(filt), .homeSpeedSetting(HOME_SPD),
    .creepSpeedSetting(CREEP_SPD), .homeAccelSetting(ACC), .softLimitSetting(softSet),
    .virtualPulsesPerRevSetting(ppr), .encoderResolution(ENC_RES), .motion_r(motion),
    .softLimitEn_r(softLim), .homeBusy_r(busy), .homeDone_r(done), .warnActive_r(warn),
    .warnCode_r(code), .pulsesPerRev_r(pulses));

  hm_axis_model hm_axis_model_i (
    .clk_sys(clk_sys), .motion(motion), .setStb(setStb), .setPos(setPos),
    .dogEn(dogEn), .fwdEnd(fwdEnd), .revEnd(revEnd), .dog(dog));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t ns seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic reset_dut(input logic [15:0] s);
    resetn = 1'b0;
    ppr = s;
    step(12);
    resetn = 1'b1;
  endtask

  // one homing attempt from position p, logging what the motion command did
  task automatic run_home(input logic [7:0] p);
    logic lastFwd;
    setPos = p;
    setStb = 1'b1;
    step(1);
    setStb = 1'b0;
    startReq = 1'b1;
    {firstFwd, lastFwd} = 2'bxx;
    {sawMove, sawCreep, badProf, limitOn} = 4'h0;
    dirChg = 0;
    lat = -1;
    for (int i = 0; i < 3000; i++)
    begin
      step(1);
      if (busy === 1'b1 && lat < 0)
        lat = i;
      if (busy === 1'b1)
        startReq = 1'b0;
      if (motion.enable === 1'b1)
      begin
        if (!sawMove)
          firstFwd = motion.forward;
        else if (motion.forward !== lastFwd)
          dirChg++;
        sawMove = 1'b1;
        lastFwd = motion.forward;
        sawCreep |= (motion.speed === CREEP_SPD);
        badProf |= (motion.accelTime !== ACC);
        badProf |= (motion.speed !== HOME_SPD) && (motion.speed !== CREEP_SPD);
      end
      limitOn |= (busy === 1'b1) && (softLim === 1'b1);
      if (i > 20 && busy !== 1'b1)
        break;
    end
    startReq = 1'b0;
    // a run that never settles counts against the verdict
    check(busy, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // pulse count is taken once after reset; a later write must not move it
  task automatic t_pulses;
    logic [15:0] s [5];
    logic [31:0] e [5];
    s = '{16'h0000, 16'h0064, 16'h01F4, 16'h0063, 16'h01F5};
    e = '{ENC_RES, 32'h0000_2710, 32'h0000_C350, 32'h0000_2710, 32'h0000_2710};
    for (int k = 0; k < 5; k++)
    begin
      reset_dut(s[k]);
      step(1);
      ppr = 16'h012C;
      step(3);
      check(pulses, e[k]);
    end
  endtask

  // start beyond the dog: out to the stroke end, back past the dog, home
  task automatic t_beyond;
    run_home(8'h5A);
    lat0 = lat;
    check(firstFwd, 1'b1);
    check(dirChg, 2);
    check(done, 1'b1);
    check(sawCreep, 1'b1);
    check(badProf, 1'b0);
    check(limitOn, 1'b0);
    check(softLim, 1'b1);
    softSet = 1'b0;
    step(2);
    check(softLim, 1'b0);
    softSet = 1'b1;
    // reverse home direction: beyond the dog now means below it
    homeFwd = 1'b0;
    run_home(8'h1E);
    check(firstFwd, 1'b0);
    check(dirChg, 2);
    check(done, 1'b1);
    homeFwd = 1'b1;
  endtask

  task automatic t_ondog;
    run_home(8'h46);
    check(firstFwd, 1'b0);
    check(dirChg, 1);
    check(done, 1'b1);
  endtask

  // missing dog: stop at the opposite end with the warning, then recover
  task automatic t_nodog;
    dogEn = 1'b0;
    run_home(8'h5A);
    check(dirChg, 1);
    check(warn, 1'b1);
    check(code, 12'h5A2);
    check(motion.enable, 1'b0);
    check(done, 1'b0);
    dogEn = 1'b1;
    run_home(8'h00);
    check(warn, 1'b0);
    check(code, 12'h000);
    check(done, 1'b1);
  endtask

  // selection inputs settle well before the start edge
  task automatic sel_case(input logic pm, input logic [2:0] ps, input logic hc,
                          input logic am, input logic expMove);
    progM = pm;
    pointSel = ps;
    homeCmd = hc;
    autoMan = am;
    step(6);
    run_home(8'h5A);
    check(sawMove, expMove);
  endtask

  task automatic t_select;
    sel_case(1'b0, 3'h2, 1'b0, 1'b1, 1'b0);
    sel_case(1'b0, 3'h0, 1'b0, 1'b0, 1'b0);
    sel_case(1'b1, 3'h5, 1'b0, 1'b1, 1'b0);
    sel_case(1'b1, 3'h5, 1'b1, 1'b1, 1'b1);
    sel_case(1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
  endtask

  // short pulses are swallowed; a held start is seen two cycles later
  task automatic t_filter;
    filt = 8'h01;
    step(10);
    startReq = 1'b1;
    step(2);
    startReq = 1'b0;
    step(20);
    check(busy, 1'b0);
    run_home(8'h5A);
    check(lat - lat0, 2);
    check(done, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog sized well above the expected run of about a thousand cycles
  initial
  begin
    step(60000);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    reset_dut(16'h0064);
    step(2);
    check({motion.enable, motion.forward, motion.speed}, 32'h0);
    check(motion.accelTime, ACC);
    check({busy, done, warn, code}, 32'h0);
    check(softLim, 1'b1);
    check(pulses, 32'h0000_2710);
    t_pulses();
    reset_dut(16'h0064);
    step(2);
    t_beyond();
    t_ondog();
    t_nodog();
    t_select();
    t_filter();
    report_and_stop();
  end
endmodule // hm_homing_tb
